// ==== hw/gpio_pull_defines.svh ====
// Purpose: Constants for the four-port pull and keep controller.
// Assumes: Byte-wide special-function register space, one clock.
// Notes: Port n owns pin bits 8n+7 down to 8n on every pin vector.
//
// Functional notes
// - A port read that is not read-modify-write returns the live pins.
// - A read-modify-write port read returns the port output data latch.
// - Every pin of all four ports works as a general input or output.
// - Four pull-down select registers at 0xE3 to 0xE6 pull a pin down.
// - Four pull-up select registers at 0xEB to 0xEE pull a pin up.
// - With both pull bits set a pin keeps its previously held level.
`ifndef GPIO_PULL_DEFINES_SVH
`define GPIO_PULL_DEFINES_SVH

`define SFR_ADDR_W 8
`define SFR_DATA_W 8
`define PORT_COUNT 4
`define PIN_COUNT 32

`define PORT0_DATA_ADDR 8'h80
`define PORT1_DATA_ADDR 8'h90
`define PORT2_DATA_ADDR 8'hA0
`define PORT3_DATA_ADDR 8'hB0
`define PORT0_PD_ADDR 8'hE3
`define PORT1_PD_ADDR 8'hE4
`define PORT2_PD_ADDR 8'hE5
`define PORT3_PD_ADDR 8'hE6
`define PORT0_PU_ADDR 8'hEB
`define PORT1_PU_ADDR 8'hEC
`define PORT2_PU_ADDR 8'hED
`define PORT3_PU_ADDR 8'hEE

`define PORT_DATA_RESET 8'hFF
`define PULL_SEL_RESET 8'h00
`define UNMAPPED_READ 8'h00
`define PIN_ZERO 32'h00000000

`endif

// ==== hw/gpio_pull_keep_control.sv ====
// Purpose: Port data latches, pin reads and pull, keep control for 4 ports.
// Assumes: Single clock, synchronous reset, byte-wide register access.
// Notes: A latch bit of zero drives the pin low; a one releases it.
`timescale 1ns/1ps
`include "gpio_pull_defines.svh"

module gpio_pull_keep_control (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [`SFR_ADDR_W-1:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [`SFR_DATA_W-1:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic i_sfr_rmw,
  input wire logic [`PIN_COUNT-1:0] i_pin,
  output logic [`SFR_DATA_W-1:0] o_sfr_rdata,
  output logic o_sfr_rvalid,
  output logic [`PIN_COUNT-1:0] o_pin_out,
  output logic [`PIN_COUNT-1:0] o_pin_oe,
  output logic [`PIN_COUNT-1:0] o_pull_up,
  output logic [`PIN_COUNT-1:0] o_pull_dn,
  output logic [`PIN_COUNT-1:0] o_keep,
  output logic [`PIN_COUNT-1:0] o_keep_level
);

  logic [`SFR_DATA_W-1:0] port0_data;
  logic [`SFR_DATA_W-1:0] port1_data;
  logic [`SFR_DATA_W-1:0] port2_data;
  logic [`SFR_DATA_W-1:0] port3_data;
  logic [`SFR_DATA_W-1:0] port0_pulldown_sel;
  logic [`SFR_DATA_W-1:0] port1_pulldown_sel;
  logic [`SFR_DATA_W-1:0] port2_pulldown_sel;
  logic [`SFR_DATA_W-1:0] port3_pulldown_sel;
  logic [`SFR_DATA_W-1:0] port0_pullup_sel;
  logic [`SFR_DATA_W-1:0] port1_pullup_sel;
  logic [`SFR_DATA_W-1:0] port2_pullup_sel;
  logic [`SFR_DATA_W-1:0] port3_pullup_sel;
  logic [`PIN_COUNT-1:0] pin_sync;
  logic [`PIN_COUNT-1:0] data_all;
  logic [`PIN_COUNT-1:0] port_pulldown_select;
  logic [`PIN_COUNT-1:0] port_pullup_select;
  logic [`PIN_COUNT-1:0] next_keep;
  logic [`SFR_DATA_W-1:0] next_rdata;
  gpio_pull_pkg::sfr_sel_t sel;
  logic [1:0] sel_port;

  // Returns the register group addressed by an SFR address; decode_port gives the port.
  function automatic gpio_pull_pkg::sfr_sel_t decode_sel(
    input logic [`SFR_ADDR_W-1:0] addr
  );
    unique case (addr)
      `PORT0_DATA_ADDR, `PORT1_DATA_ADDR,
      `PORT2_DATA_ADDR, `PORT3_DATA_ADDR: decode_sel = gpio_pull_pkg::SEL_DATA;
      `PORT0_PD_ADDR, `PORT1_PD_ADDR,
      `PORT2_PD_ADDR, `PORT3_PD_ADDR: decode_sel = gpio_pull_pkg::SEL_PD;
      `PORT0_PU_ADDR, `PORT1_PU_ADDR,
      `PORT2_PU_ADDR, `PORT3_PU_ADDR: decode_sel = gpio_pull_pkg::SEL_PU;
      default: decode_sel = gpio_pull_pkg::SEL_NONE;
    endcase
  endfunction : decode_sel

  function automatic logic [1:0] decode_port(
    input logic [`SFR_ADDR_W-1:0] addr
  );
    unique case (addr)
      `PORT1_DATA_ADDR, `PORT1_PD_ADDR, `PORT1_PU_ADDR: decode_port = 2'h1;
      `PORT2_DATA_ADDR, `PORT2_PD_ADDR, `PORT2_PU_ADDR: decode_port = 2'h2;
      `PORT3_DATA_ADDR, `PORT3_PD_ADDR, `PORT3_PU_ADDR: decode_port = 2'h3;
      default: decode_port = 2'h0;
    endcase
  endfunction : decode_port

  function automatic logic [`SFR_DATA_W-1:0] pick_byte(
    input logic [`PIN_COUNT-1:0] vec,
    input logic [1:0] port
  );
    pick_byte = vec[port*`SFR_DATA_W +: `SFR_DATA_W];
  endfunction : pick_byte

  port_pin_sync u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pin(i_pin),
    .o_pin(pin_sync)
  );

  assign sel = decode_sel(i_sfr_addr);
  assign sel_port = decode_port(i_sfr_addr);
  assign data_all = {port3_data, port2_data, port1_data, port0_data};
  assign port_pulldown_select = {port3_pulldown_sel, port2_pulldown_sel,
                                 port1_pulldown_sel, port0_pulldown_sel};
  assign port_pullup_select = {port3_pullup_sel, port2_pullup_sel,
                               port1_pullup_sel, port0_pullup_sel};

  // Port output data latches.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      port0_data <= `PORT_DATA_RESET;
      port1_data <= `PORT_DATA_RESET;
      port2_data <= `PORT_DATA_RESET;
      port3_data <= `PORT_DATA_RESET;
    end else if (i_sfr_wr && sel == gpio_pull_pkg::SEL_DATA) begin
      unique case (sel_port)
        2'h0: port0_data <= i_sfr_wdata;
        2'h1: port1_data <= i_sfr_wdata;
        2'h2: port2_data <= i_sfr_wdata;
        2'h3: port3_data <= i_sfr_wdata;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      port0_pulldown_sel <= `PULL_SEL_RESET;
      port1_pulldown_sel <= `PULL_SEL_RESET;
      port2_pulldown_sel <= `PULL_SEL_RESET;
      port3_pulldown_sel <= `PULL_SEL_RESET;
    end else if (i_sfr_wr && sel == gpio_pull_pkg::SEL_PD) begin
      unique case (sel_port)
        2'h0: port0_pulldown_sel <= i_sfr_wdata;
        2'h1: port1_pulldown_sel <= i_sfr_wdata;
        2'h2: port2_pulldown_sel <= i_sfr_wdata;
        2'h3: port3_pulldown_sel <= i_sfr_wdata;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      port0_pullup_sel <= `PULL_SEL_RESET;
      port1_pullup_sel <= `PULL_SEL_RESET;
      port2_pullup_sel <= `PULL_SEL_RESET;
      port3_pullup_sel <= `PULL_SEL_RESET;
    end else if (i_sfr_wr && sel == gpio_pull_pkg::SEL_PU) begin
      unique case (sel_port)
        2'h0: port0_pullup_sel <= i_sfr_wdata;
        2'h1: port1_pullup_sel <= i_sfr_wdata;
        2'h2: port2_pullup_sel <= i_sfr_wdata;
        2'h3: port3_pullup_sel <= i_sfr_wdata;
      endcase
    end
  end

  // Selects read data for the addressed register.
  always_comb begin
    next_rdata = `UNMAPPED_READ;
    unique case (sel)
      gpio_pull_pkg::SEL_DATA: begin
        if (i_sfr_rmw) begin
          next_rdata = pick_byte(data_all, sel_port);
        end else begin
          next_rdata = pick_byte(pin_sync, sel_port);
        end
      end
      gpio_pull_pkg::SEL_PD: next_rdata = pick_byte(port_pulldown_select,
                                                    sel_port);
      gpio_pull_pkg::SEL_PU: next_rdata = pick_byte(port_pullup_select,
                                                    sel_port);
      default: next_rdata = `UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sfr_rdata <= `UNMAPPED_READ;
      o_sfr_rvalid <= 1'b0;
    end else begin
      o_sfr_rvalid <= i_sfr_rd;
      if (i_sfr_rd) begin
        o_sfr_rdata <= next_rdata;
      end
    end
  end

  // latch zero drives low, one releases.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pin_out <= `PIN_ZERO;
      o_pin_oe <= `PIN_ZERO;
    end else begin
      o_pin_out <= `PIN_ZERO;
      o_pin_oe <= ~data_all;
    end
  end

  // both bits clear give no pull.
  assign next_keep = port_pullup_select & port_pulldown_select;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pull_up <= `PIN_ZERO;
      o_pull_dn <= `PIN_ZERO;
      o_keep <= `PIN_ZERO;
    end else begin
      o_pull_up <= port_pullup_select & ~port_pulldown_select;
      o_pull_dn <= port_pulldown_select & ~port_pullup_select;
      o_keep <= next_keep;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_keep_level <= `PIN_ZERO;
    end else begin
      o_keep_level <= (o_keep_level & o_keep) | (pin_sync & ~o_keep);
    end
  end

  pin_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_sfr_rd && sel == gpio_pull_pkg::SEL_DATA && !i_sfr_rmw) |=>
    (o_sfr_rvalid && o_sfr_rdata == pick_byte($past(pin_sync),
                                              $past(sel_port))))
    else $error("Plain port read did not return pins.");

  rmw_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_sfr_rd && sel == gpio_pull_pkg::SEL_DATA && i_sfr_rmw) |=>
    (o_sfr_rdata == pick_byte($past(data_all), $past(sel_port))))
    else $error("Read-modify-write read did not return latch.");

  pin_drive_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_sfr_wr && sel == gpio_pull_pkg::SEL_DATA) |-> ##2
    (pick_byte(o_pin_oe, $past(sel_port, 2)) == ~$past(i_sfr_wdata, 2)))
    else $error("Pin drive does not follow written latch.");

  pulldown_write_a: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (i_sfr_wr && sel == gpio_pull_pkg::SEL_PD) |=> ##1
    ((pick_byte(o_pull_dn | o_keep, $past(sel_port, 2))) ==
     $past(i_sfr_wdata, 2)))
    else $error("Pull-down select not applied to pins.");

  pullup_write_a: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (i_sfr_wr && sel == gpio_pull_pkg::SEL_PU) |=> ##1
    ((pick_byte(o_pull_up | o_keep, $past(sel_port, 2))) ==
     $past(i_sfr_wdata, 2)))
    else $error("Pull-up select not applied to pins.");

  keep_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ((o_keep & $past(o_keep) & (o_keep_level ^ $past(o_keep_level))) ==
     `PIN_ZERO))
    else $error("Kept level changed during keep.");

  no_pull_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (((o_pull_up | o_pull_dn | o_keep) &
      ~$past(port_pullup_select | port_pulldown_select)) == `PIN_ZERO))
    else $error("Pull active on a pin with both bits clear.");

  keep_seen_c: cover property (@(posedge i_clk) disable iff (i_rst)
    (o_keep != `PIN_ZERO) [*3]);
  rmw_read_c: cover property (@(posedge i_clk) disable iff (i_rst)
    i_sfr_rd && i_sfr_rmw && sel == gpio_pull_pkg::SEL_DATA);
  pin_read_c: cover property (@(posedge i_clk) disable iff (i_rst)
    i_sfr_rd && !i_sfr_rmw && sel == gpio_pull_pkg::SEL_DATA);
  pullup_c: cover property (@(posedge i_clk) disable iff (i_rst)
    o_pull_up != `PIN_ZERO);

endmodule : gpio_pull_keep_control

// ==== hw/gpio_pull_pkg.sv ====
// Purpose: Types shared by the pull and keep controller.
// Assumes: The defines header is compiled alongside.
// Notes: Mode codes are the pull-up bit over the pull-down bit.
package gpio_pull_pkg;

  typedef enum logic [1:0] {
    PULL_NONE = 2'h0,
    PULL_DOWN = 2'h1,
    PULL_UP = 2'h2,
    PULL_KEEP = 2'h3
  } pull_mode_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_DATA = 3'h1,
    SEL_PD = 3'h2,
    SEL_PU = 3'h3
  } sfr_sel_t;

endpackage : gpio_pull_pkg

// ==== hw/port_pin_sync.sv ====
// Purpose: Two-stage synchroniser for all port pin inputs.
// Assumes: Pins change with no relation to the processor clock.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/1ps
`include "gpio_pull_defines.svh"

module port_pin_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [`PIN_COUNT-1:0] i_pin,
  output logic [`PIN_COUNT-1:0] o_pin
);

  logic [`PIN_COUNT-1:0] meta;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= `PIN_ZERO;
      o_pin <= `PIN_ZERO;
    end else begin
      meta <= i_pin;
      o_pin <= meta;
    end
  end

endmodule : port_pin_sync

// ==== test/pin_side_model.sv ====
// Purpose: Pin-side model for the four ports.
// Assumes: External drivers overpower pulls and keepers.
// Notes: An undriven pin with no pull toggles every cycle.
`timescale 1ns/1ps
`include "gpio_pull_defines.svh"

module pin_side_model (
  input wire logic i_clk,
  input wire logic [`PIN_COUNT-1:0] i_out,
  input wire logic [`PIN_COUNT-1:0] i_oe,
  input wire logic [`PIN_COUNT-1:0] i_up,
  input wire logic [`PIN_COUNT-1:0] i_dn,
  input wire logic [`PIN_COUNT-1:0] i_keep,
  input wire logic [`PIN_COUNT-1:0] i_keep_level,
  input wire logic [`PIN_COUNT-1:0] i_ext_en,
  input wire logic [`PIN_COUNT-1:0] i_ext_val,
  output logic [`PIN_COUNT-1:0] o_pin
);
  logic [`PIN_COUNT-1:0] flt = `PIN_ZERO;
  logic [`PIN_COUNT-1:0] free;
  always @(posedge i_clk) flt <= ~flt;
  assign free = i_up | (i_keep & i_keep_level)
    | (~i_up & ~i_dn & ~i_keep & flt);
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
    | (~i_oe & ~i_ext_en & free);
endmodule : pin_side_model

// ==== test/test_gpio_pull_keep_control.sv ====
// Purpose: Self-checking bench for the pull and keep controller.
// Assumes: Bench drives inputs by non-blocking assignment at rising edges.
// Notes: Pull registers are walked by a table, then awkward cases.
`timescale 1ns/1ps
`include "gpio_pull_defines.svh"

module test_gpio_pull_keep_control;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  localparam logic [31:0] PD_V = 32'h00FF0F33;
  localparam logic [31:0] PU_V = 32'h00FFF055;
  logic i_clk = 1'b0, i_rst = 1'b1, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0;
  logic i_sfr_rmw = 1'b0, rv;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, rd;
  logic [31:0] i_pin, ext_en = 32'hFFFFFFFF, ext_val = 32'hA5A5A5A5;
  logic [7:0] o_sfr_rdata;
  logic o_sfr_rvalid;
  logic [31:0] o_pin_out, o_pin_oe, o_pull_up, o_pull_dn, o_keep, o_keep_level;
  int n_mismatch = 0, total_checks = 0, cycles = 0;
  row_t rows [9] = '{'{8'hE3, 8'h33, 8'h33}, '{8'hE4, 8'h0F, 8'h0F},
    '{8'hE5, 8'hFF, 8'hFF}, '{8'hE6, 8'h00, 8'h00}, '{8'hEB, 8'h55, 8'h55},
    '{8'hEC, 8'hF0, 8'hF0}, '{8'hED, 8'hFF, 8'hFF}, '{8'hEE, 8'h00, 8'h00},
    '{8'h50, 8'h5A, 8'h00}};

  gpio_pull_keep_control dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
    .i_sfr_rd(i_sfr_rd), .i_sfr_rmw(i_sfr_rmw), .i_pin(i_pin),
    .o_sfr_rdata(o_sfr_rdata), .o_sfr_rvalid(o_sfr_rvalid),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pull_up(o_pull_up),
    .o_pull_dn(o_pull_dn), .o_keep(o_keep), .o_keep_level(o_keep_level));
  pin_side_model pins (.i_clk(i_clk), .i_out(o_pin_out), .i_oe(o_pin_oe),
    .i_up(o_pull_up), .i_dn(o_pull_dn), .i_keep(o_keep),
    .i_keep_level(o_keep_level), .i_ext_en(ext_en), .i_ext_val(ext_val),
    .o_pin(i_pin));

  always #50 i_clk = ~i_clk;

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    @(posedge i_clk);
    i_sfr_wr <= 1'b0;
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] a, input logic m,
                          output logic [7:0] d);
    @(posedge i_clk);
    i_sfr_addr <= a;
    i_sfr_rmw <= m;
    i_sfr_rd <= 1'b1;
    @(posedge i_clk);
    i_sfr_rd <= 1'b0;
    i_sfr_rmw <= 1'b0;
    #1;
    d = o_sfr_rdata;
    rv = o_sfr_rvalid;
  endtask : sfr_read

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    check(o_pull_up | o_pull_dn | o_keep | o_pin_oe, 32'h0);
    foreach (rows[i]) begin
      sfr_read(rows[i].a, 1'b0, rd);
      check(32'(rd), 32'h0);
      check(32'(rv), 32'h1);
      sfr_write(rows[i].a, rows[i].d);
      sfr_read(rows[i].a, 1'b0, rd);
      check(32'(rd), 32'(rows[i].e));
    end
    check(o_pull_up, PU_V & ~PD_V);
    check(o_pull_dn, PD_V & ~PU_V);
    check(o_keep, PU_V & PD_V);
    sfr_write(8'hEB, 8'h54);
    repeat (4) @(posedge i_clk);
    check(32'(o_keep_level[0]), 32'h1);
    sfr_write(8'hEB, 8'h55);
    ext_val[0] <= 1'b0;
    repeat (4) @(posedge i_clk);
    check(32'(o_keep_level[0]), 32'h1);
    ext_en[0] <= 1'b0;
    repeat (4) @(posedge i_clk);
    sfr_read(8'h80, 1'b0, rd);
    check(32'(rd[0]), 32'h1);
    ext_en[0] <= 1'b1;
    ext_val[0] <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      sfr_write(8'h80 + 8'(p * 16), 8'hF0);
      repeat (4) @(posedge i_clk);
      check(32'(o_pin_oe[p*8+:8]), 32'h0F);
      check(o_pin_out, 32'h0);
      sfr_read(8'h80 + 8'(p * 16), 1'b0, rd);
      check(32'(rd), 32'hA0);
      sfr_read(8'h80 + 8'(p * 16), 1'b1, rd);
      check(32'(rd), 32'hF0);
    end
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    check(o_pull_up | o_pull_dn | o_keep | o_pin_oe, 32'h0);
    sfr_read(8'hEB, 1'b0, rd);
    check(32'(rd), 32'h0);
    sfr_read(8'h80, 1'b1, rd);
    check(32'(rd), 32'hFF);
    give_verdict();
  end
endmodule : test_gpio_pull_keep_control
